// [rtl/display_shadow_control_flow.sv]
`timescale 1ns/1ps
`default_nettype none
module display_shadow_control_flow
    import shadow_flow_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic timing_gen_enable_in,
    input wire logic capture_enable_in,
    input wire logic shadow_enable_in,
    input wire logic overlay_enable_in,
    input wire logic [PIX_W-1:0] background_color_in,
    input wire logic [H_W-1:0] primary_start_x_in,
    input wire logic hsync_polarity_in,
    input wire logic vsync_polarity_in,
    input wire logic token_generate_in,
    input wire logic mem_sync_trigger_in,
    input wire logic cap_sync_trigger_in,
    input wire logic [N_FLAGS-1:0] flag_clear_in,
    input wire logic mem_valid_in,
    output logic mem_ready_out,
    input wire logic [PIX_W-1:0] mem_data_in,
    output logic timing_active_status_out,
    output logic [N_FLAGS-1:0] flags_out,
    output logic hsync_out,
    output logic vsync_out,
    output logic data_enable_out,
    output logic [PIX_W-1:0] pixel_out
);
    // A single-entry buffer could not hold a word while the next one arrives
    if (DEPTH < 2) begin : g_depth_check
        $error("display_shadow_control_flow needs a fifo depth of 2 or more");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic run_q;
    logic [H_W-1:0] h_q;
    logic [V_W-1:0] v_q;
    logic tok_pend_q, mem_pend_q, cap_pend_q;
    logic [PIX_W-1:0] bg_shd_q, bg_act_q;
    logic [H_W-1:0] px_shd_q, px_act_q;
    mix_mode_t mix_q;
    logic [N_FLAGS-1:0] flags_q, ev_w;
    logic fifo_valid;
    logic [PIX_W-1:0] fifo_data;

    ////////////////////////////////////////////////////////////////////////////
    // Timing decode
    wire h_last_w = (h_q == H_W'(H_TOT - 1));
    wire v_last_w = (v_q == V_W'(V_TOT - 1));
    wire frame_end_w = run_q && h_last_w && v_last_w;
    wire h_act_w = (h_q >= H_W'(H_SBP)) && (h_q < H_W'(H_SBP + H_ACT));
    wire v_act_w = (v_q >= V_W'(V_SBP)) && (v_q < V_W'(V_SBP + V_ACT));
    wire act_w = run_q && h_act_w && v_act_w;
    wire [H_W-1:0] x_w = h_q - H_W'(H_SBP);
    wire border_w = act_w && (h_q == H_W'(H_SBP) || h_q == H_W'(H_SBP + H_ACT - 1)
                    || v_q == V_W'(V_SBP) || v_q == V_W'(V_SBP + V_ACT - 1));
    wire hs_w = run_q && (h_q < H_W'(H_SYNC));
    wire vs_w = run_q && (v_q < V_W'(V_SYNC));

    // Run control: start at once, stop only at a frame boundary with nothing pending
    wire start_w = !run_q && timing_gen_enable_in; // R9
    wire stop_w = frame_end_w && !timing_gen_enable_in
                  && !mem_pend_q && !cap_pend_q && !tok_pend_q; // R11
    wire run_d = start_w || (run_q && !stop_w);

    // Shadow loads land on the frame boundary, or at once while idle
    wire load_slot_w = frame_end_w || !run_q; // R13
    wire tok_load_w = tok_pend_q && load_slot_w; // R15
    wire mem_load_w = mem_pend_q && load_slot_w; // R16
    wire cap_load_w = cap_pend_q && load_slot_w;

    // Held frames: the memory stream is not drained while its sync waits
    wire in_overlay_w = act_w && !border_w && (x_w >= px_act_q)
                        && mix_q == MIX_OVERLAY; // R2
    wire pop_w = in_overlay_w && fifo_valid && !mem_pend_q; // R16
    wire [PIX_W-1:0] pix_w = pop_w ? fifo_data : (act_w ? bg_act_q : '0); // R23

    // Position events: vblank start, frame end, next frame kick for both streams
    wire pos_kick_w = run_q && v_last_w && (h_q == H_W'(H_TOT - 2));
    wire pos2_w = run_q && (v_q == V_W'(V_SBP + V_ACT)) && (h_q == '0);
    wire pos3_w = frame_end_w;

    ////////////////////////////////////////////////////////////////////////////
    // Event collection
    always_comb begin
        ev_w = '0;
        ev_w[FL_DISP_SHD] = tok_load_w; // R15
        ev_w[FL_PRIM_SHD] = mem_load_w; // R17
        ev_w[FL_SEC_SHD] = cap_load_w; // R17
        ev_w[FL_SEQ_DONE] = stop_w; // R12
        ev_w[FL_MEM_FC] = frame_end_w;
        ev_w[FL_CAP_FC] = frame_end_w && capture_enable_in;
        ev_w[FL_POS0] = pos_kick_w;
        ev_w[FL_POS1] = pos_kick_w && capture_enable_in;
        ev_w[FL_POS2] = pos2_w;
        ev_w[FL_POS3] = pos3_w;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame counters and run state
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
            h_q <= '0;
            v_q <= '0;
        end else begin
            run_q <= run_d;
            h_q <= (!run_q || h_last_w) ? '0 : h_q + H_W'(1); // R1
            if (!run_q || frame_end_w) begin
                v_q <= '0;
            end else if (h_last_w) begin
                v_q <= v_q + V_W'(1);
            end
        end
    end

    // Pending load requests; a new trigger wins over the completing load
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tok_pend_q <= 1'b0;
            mem_pend_q <= 1'b0;
            cap_pend_q <= 1'b0;
        end else begin
            tok_pend_q <= token_generate_in || (tok_pend_q && !tok_load_w); // R15
            mem_pend_q <= mem_sync_trigger_in || (mem_pend_q && !mem_load_w); // R16
            cap_pend_q <= cap_sync_trigger_in || (cap_pend_q && !cap_load_w); // R16
        end
    end

    // Shadow and active copies; direct write bypasses the shadow stage
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bg_shd_q <= BG_RESET;
            bg_act_q <= BG_RESET; // R1
            px_shd_q <= PSTARTX_RESET;
            px_act_q <= PSTARTX_RESET;
            mix_q <= MIX_NEUTRAL; // R5
        end else begin
            bg_shd_q <= background_color_in;
            px_shd_q <= primary_start_x_in;
            mix_q <= overlay_enable_in ? MIX_OVERLAY : MIX_NEUTRAL;
            if (!shadow_enable_in) begin
                bg_act_q <= background_color_in; // R7
                px_act_q <= primary_start_x_in; // R7
            end else begin
                if (tok_load_w) begin
                    bg_act_q <= bg_shd_q; // R13
                end
                if (mem_load_w) begin
                    px_act_q <= px_shd_q; // R13
                end
            end
        end
    end

    // Sticky flags: an event in the clearing cycle survives
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~flag_clear_in) | ev_w; // R24
        end
    end

    // Registered outputs, syncs high active unless polarity inverts them
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            data_enable_out <= 1'b0;
            pixel_out <= '0;
            timing_active_status_out <= 1'b0;
        end else begin
            hsync_out <= hs_w ^ hsync_polarity_in; // R1
            vsync_out <= vs_w ^ vsync_polarity_in;
            data_enable_out <= act_w;
            pixel_out <= pix_w; // R2
            timing_active_status_out <= run_d; // R12
        end
    end
    assign flags_out = flags_q;

    ////////////////////////////////////////////////////////////////////////////
    // Memory stream buffer; its ready is the upstream back-pressure
    pixel_fifo #(.WIDTH(PIX_W), .DEPTH(DEPTH)) mem_fifo (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(mem_valid_in),
        .in_ready_out(mem_ready_out),
        .in_data_in(mem_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop_w),
        .out_data_out(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    start_run_a: assert property (!run_q && timing_gen_enable_in |=> run_q && timing_active_status_out) // R9
        else $error("timing did not start");
    stop_drain_a: assert property (run_q && !frame_end_w |=> run_q) // R11
        else $error("timing stopped mid frame");
    seq_done_a: assert property ($fell(timing_active_status_out) |-> flags_q[FL_SEQ_DONE]) // R12
        else $error("stop without sequence complete flag");
    frame_wrap_a: assert property (frame_end_w |=> h_q == '0 && v_q == '0 // R1
        && (run_q || !$past(timing_gen_enable_in)))
        else $error("frame did not wrap at total size");
    token_load_a: assert property (tok_pend_q && !run_q && shadow_enable_in // R15
        |=> flags_q[FL_DISP_SHD] && bg_act_q == $past(bg_shd_q))
        else $error("token load missing");
    direct_write_a: assert property (!shadow_enable_in |=> bg_act_q == $past(background_color_in)) // R7
        else $error("direct write not applied");
    sync_hold_a: assert property (mem_pend_q && fifo_valid |=> fifo_valid) // R16
        else $error("memory frame drained during sync");
    sync_flag_a: assert property (mem_pend_q && load_slot_w // R17
        |=> flags_q[FL_PRIM_SHD] && (!mem_pend_q || $past(mem_sync_trigger_in)))
        else $error("sync load flag missing");
    border_bg_a: assert property (border_w |=> pixel_out == $past(bg_act_q) && data_enable_out) // R2
        else $error("border pixel not background");
    sticky_a: assert property (flags_q[FL_MEM_FC] && !flag_clear_in[FL_MEM_FC] |=> flags_q[FL_MEM_FC]) // R24
        else $error("flag lost without clear");

    start_c: cover property (start_w ##1 run_q);
    stop_c: cover property (stop_w);
    sync_c: cover property (mem_load_w && run_q);
    overlay_c: cover property (pop_w);
endmodule
`default_nettype wire

// [rtl/shadow_flow_pkg.sv]
// Summary of operation
// R1 - Reset defaults give 320x240 timing, high syncs
// R2 - Active area border painted in background colour
// R3 - Software encodes disabled ports as zero
// R4 - Software connects primary input of active units
// R5 - Unbypassable units reset into neutral mode
// R6 - Software sets fetch reset, clock gate to run
// R7 - Shadowing disabled applies writes directly
// R8 - Software selects single-trigger sync modes
// R9 - Timing enable starts display and memory streams
// R10 - Software orders capture enable around timing enable
// R11 - Timing stop waits for pending frames
// R12 - Stop completion clears status, flags sequence done
// R13 - Shadowed writes load consistently per frame
// R14 - Software sets token endpoints and load select
// R15 - Token write loads display shadows, flags it
// R16 - Sync trigger holds frames, loads shadows, resumes
// R17 - Sync load flags matching frame generator input
// R18 - Software loads all shadows before display start
// R19 - Software changes display settings within blanking
// R20 - Software changes stream settings between frames
// R21 - Software swaps buffers by synchronized shadow load
// R22 - Software sets low sync polarity for panels
// R23 - Timing runs free with background, no stream
// R24 - Events set sticky flags until software clears
package shadow_flow_pkg;
    localparam int H_ACT = 320;
    localparam int V_ACT = 240;
    localparam int H_TOT = 400;
    localparam int V_TOT = 253;
    localparam int H_SYNC = 32;
    localparam int V_SYNC = 4;
    localparam int H_SBP = 72;
    localparam int V_SBP = 10;
    localparam int H_W = 9;
    localparam int V_W = 8;
    localparam int PIX_W = 24;
    localparam logic [PIX_W-1:0] BG_RESET = 24'hffffff;
    localparam logic [H_W-1:0] PSTARTX_RESET = 9'h000;
    localparam int N_FLAGS = 10;
    localparam int FL_DISP_SHD = 0;
    localparam int FL_PRIM_SHD = 1;
    localparam int FL_SEC_SHD = 2;
    localparam int FL_SEQ_DONE = 3;
    localparam int FL_MEM_FC = 4;
    localparam int FL_CAP_FC = 5;
    localparam int FL_POS0 = 6;
    localparam int FL_POS1 = 7;
    localparam int FL_POS2 = 8;
    localparam int FL_POS3 = 9;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic {MIX_NEUTRAL, MIX_OVERLAY} mix_mode_t;
endpackage

// [rtl/pixel_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("pixel_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, valid_q;
    wire push_w = in_valid_in && ready_q;
    wire pop_w = out_ready_in && valid_q;

    // Count next value; ready and valid kept as flops so the ports come straight from them
    assign cnt_d = cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
    assign in_ready_out = ready_q;
    assign out_valid_out = valid_q;
    assign out_data_out = mem_q[rd_q];

    // Storage and pointers
    always_ff @(posedge clk_in) begin
        if (push_w) begin
            mem_q[wr_q] <= in_data_in;
        end
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push_w);
            rd_q <= rd_q + AW'(pop_w);
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != (AW+1)'(DEPTH));
            valid_q <= (cnt_d != '0);
        end
    end
endmodule
`default_nettype wire

// [test/mem_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mem_source_model
    import shadow_flow_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ready_in,
    input wire logic stall_in,
    output logic valid_out,
    output logic [PIX_W-1:0] data_out,
    output int count_out
);
    logic taken;
    initial begin
        valid_out = 1'b0;
        data_out = 24'h000000;
        count_out = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Word n carries 100000+n; a word is held until ready is seen at an edge.
    // While idle the data toggles, so a sink that samples a stale word shows it.
    always @(posedge clk_in) begin
        taken = valid_out && ready_in;
        #1;
        if (rst_in) begin
            valid_out = 1'b0;
            count_out = 0;
        end else begin
            if (taken) count_out++;
            if (taken || !valid_out) begin
                valid_out = !stall_in;
                data_out = valid_out ? 24'h100000 + count_out[PIX_W-1:0] : ~data_out;
            end
        end
    end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import shadow_flow_pkg::*;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, cap_en = 1'b0, shd = 1'b0, ovl = 1'b0;
    logic hpol = 1'b0, vpol = 1'b0, stall = 1'b0, status, hs, vs, de, mrdy, mval;
    logic [2:0] trig = 3'h0;
    logic [PIX_W-1:0] bg = 24'h000000, pix, mdata;
    logic [H_W-1:0] psx = 9'h000;
    logic [N_FLAGS-1:0] fclr = 10'h000, flags;
    int fail_count = 0, total_checks = 0, cycles = 0, de_count = 0, words;
    localparam logic [PIX_W-1:0] COL_A = 24'h12ab34;
    localparam logic [PIX_W-1:0] COL_B = 24'h00ff00;
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    display_shadow_control_flow i_display_shadow_control_flow (.sys_clk_in(clk), .rst_in(rst),
        .timing_gen_enable_in(en), .capture_enable_in(cap_en), .shadow_enable_in(shd),
        .overlay_enable_in(ovl), .background_color_in(bg), .primary_start_x_in(psx),
        .hsync_polarity_in(hpol), .vsync_polarity_in(vpol), .token_generate_in(trig[0]),
        .mem_sync_trigger_in(trig[1]), .cap_sync_trigger_in(trig[2]), .flag_clear_in(fclr),
        .mem_valid_in(mval), .mem_ready_out(mrdy), .mem_data_in(mdata),
        .timing_active_status_out(status), .flags_out(flags), .hsync_out(hs), .vsync_out(vs),
        .data_enable_out(de), .pixel_out(pix));
    mem_source_model i_mem_source_model (.clk_in(clk), .rst_in(rst), .ready_in(mrdy),
        .stall_in(stall), .valid_out(mval), .data_out(mdata), .count_out(words));
    ////////////////////////////////////////////////////////////////////////
    // Source stalls every other cycle; the frame is long, so a hang cap is needed
    always @(posedge clk) begin
        stall <= ~stall;
        cycles++;
        if (cycles == 105000) begin
            fail_count++;
            give_verdict();
        end
    end
    // Active pixels are counted mid-cycle, where the registered enable has settled
    always @(negedge clk) begin
        if (de === 1'b1) de_count++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for an active pixel
    task automatic wait_de();
        int n;
        for (n = 0; n < 5000 && de !== 1'b1; n++) tick(1);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        tick(12);
        rst = 1'b0;
        tick(1);
        chk({status, hs, vs, de}, 0);
        chk(flags, 0);
        shd = 1'b1;
        bg = COL_A;
        psx = 9'h010;
        // Each load trigger raises its own sticky flag, which holds until cleared
        for (int i = 0; i < 3; i++) begin
            trig[i] = 1'b1;
            tick(1);
            trig = 3'h0;
            tick(5);
            chk(flags[i], 1);
            fclr = 10'(1 << i);
            tick(1);
            fclr = 10'h000;
            tick(1);
            chk(flags[i], 0);
        end
        bg = COL_B;
        tick(40);
        chk({mrdy, 8'(words)}, {1'b0, 8'd16});
        ovl = 1'b1;
        en = 1'b1;
        tick(2);
        chk(status, 1);
        chk({hs, vs}, 2'b11);
        cap_en = 1'b1;
        hpol = 1'b1;
        vpol = 1'b1;
        tick(2);
        chk({hs, vs}, 2'b00);
        hpol = 1'b0;
        vpol = 1'b0;
        cap_en = 1'b0;
        tick(1);
        en = 1'b0;
        // Row 10 is all border; row 11 shows background up to the loaded start x
        wait_de();
        chk(pix, COL_A);
        tick(415);
        chk(pix, COL_A);
        tick(1);
        chk(pix, 24'h100000);
        shd = 1'b0;
        tick(303);
        chk(pix, COL_B);
        chk(status, 1);
        // Wait for vertical blanking as software would before unshadowed writes
        fclr = 10'h110;
        tick(1);
        fclr = 10'h000;
        for (n = 0; n < 100000 && flags[FL_POS2] !== 1'b1; n++) tick(1);
        chk({flags[FL_POS2], de}, 2'b10);
        for (n = 0; n < 110000 && status !== 1'b0; n++) tick(1);
        chk(status, 0);
        chk(flags[FL_SEQ_DONE], 1);
        chk(flags, 10'h358);
        chk(de_count, H_ACT * V_ACT);
        chk(words > 16, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
